//--- compare_output_modes.sv
// Compare output modes 0, 1 and 2 with an APB register file.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module compare_output_modes #(
  parameter int W = 16,
  parameter int T2_REGS = 5,
  parameter int CT_REGS = 8,
  parameter int P5_PINS = 8
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timers, synchronous counts
  input wire logic [W-1:0] t2_count,
  input wire logic [W-1:0] ct_count,
  // Pin levels seen by reads
  input wire logic [T2_REGS-1:0] port1_pin_in,
  input wire logic [P5_PINS-1:0] port5_pin_in,
  // Compare outputs
  output logic [T2_REGS-1:0] port1_out,
  output logic [CT_REGS-1:0] port4_out,
  output logic [P5_PINS-1:0] port5_out,
  output logic set_match_irq,
  output logic clr_match_irq
);
  ////////////////////////////////////////////////////////////////////////
  logic access;
  logic wr;
  logic rd_first;
  logic hit;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_data;

  logic timer2_compare_mode_select_q;
  logic [T2_REGS-1:0] t2_en_q;
  logic [7:0] fourth_q;
  logic [CT_REGS-1:0] ct_en_q;
  logic [W-1:0] t2_cmp_q [T2_REGS];
  logic [W-1:0] ct_cmp_q [CT_REGS];
  logic [W-1:0] set_cmp_q;
  logic [W-1:0] clr_cmp_q;
  logic [7:0] set_mask_q;
  logic [7:0] clr_mask_q;
  logic [T2_REGS-1:0] port1_latch_q;
  logic [CT_REGS-1:0] port4_latch_q;
  logic [P5_PINS-1:0] port5_q;
  logic [1:0] events_q;

  logic [T2_REGS-1:0] t2_eq;
  logic [T2_REGS-1:0] t2_pwm;
  logic [T2_REGS-1:0] shadow;
  logic [T2_REGS-1:0] m1_port;
  logic [T2_REGS-1:0] m1_wr;
  logic [CT_REGS-1:0] ct_pwm;
  logic set_eq;
  logic clr_eq;
  logic set_eq_q;
  logic clr_eq_q;
  logic set_hit;
  logic clr_hit;
  logic mode2_on;
  logic [2:0] pin_count;
  logic [P5_PINS-1:0] pin_sel;
  logic [P5_PINS-1:0] port5_d;
  logic port1_wr;

  ////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, so every access takes three cycles
  assign access = psel && penable;
  assign rd_first = access && !pready_q;
  assign hit = access && pready_q;
  assign wr = hit && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= rd_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= compare_pkg::RD_ZERO;
      pslverr_q <= 1'b0;
    end else if (rd_first) begin
      prdata_q <= pwrite ? compare_pkg::RD_ZERO : rd_data;
      pslverr_q <= !addr_ok(paddr);
    end else if (!access) begin
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = (a <= compare_pkg::OFF_PORT4) && (a[1:0] == 2'h0);
    ok = ok && !((a >= 8'(compare_pkg::OFF_T2_CMP + 8'(4 * T2_REGS))) &&
                 (a < compare_pkg::OFF_SET_CMP));
    ok = ok || ((a >= compare_pkg::OFF_CT_CMP) && (a[1:0] == 2'h0) &&
                (a < 8'(compare_pkg::OFF_CT_CMP + 8'(4 * CT_REGS))));
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_compare_mode_select_q <= 1'b0;
      t2_en_q <= '0;
      fourth_q <= compare_pkg::BYTE_RESET;
      ct_en_q <= '0;
    end else if (wr) begin
      if (paddr == compare_pkg::OFF_CTRL) begin
        timer2_compare_mode_select_q <= pwdata[compare_pkg::CTRL_TIMER2_COMPARE_MODE_SELECT_BIT]; // see R20
      end
      if (paddr == compare_pkg::OFF_T2_EN) begin
        t2_en_q <= pwdata[T2_REGS-1:0];
      end
      if (paddr == compare_pkg::OFF_FOURTH) begin
        fourth_q <= pwdata[7:0]; // see R15
      end
      if (paddr == compare_pkg::OFF_CT_EN) begin
        ct_en_q <= pwdata[CT_REGS-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_cmp_q <= compare_pkg::CMP_RESET;
      clr_cmp_q <= compare_pkg::CMP_RESET;
      set_mask_q <= compare_pkg::BYTE_RESET;
      clr_mask_q <= compare_pkg::BYTE_RESET;
    end else if (wr) begin
      if (paddr == compare_pkg::OFF_SET_CMP) begin
        set_cmp_q <= pwdata[W-1:0]; // see R10
      end
      if (paddr == compare_pkg::OFF_CLR_CMP) begin
        clr_cmp_q <= pwdata[W-1:0]; // see R10
      end
      if (paddr == compare_pkg::OFF_SET_MASK) begin
        set_mask_q <= pwdata[7:0];
      end
      if (paddr == compare_pkg::OFF_CLR_MASK) begin
        clr_mask_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < T2_REGS; i++) begin
        t2_cmp_q[i] <= compare_pkg::CMP_RESET;
      end
    end else if (wr) begin
      for (int i = 0; i < T2_REGS; i++) begin
        if (paddr == 8'(compare_pkg::OFF_T2_CMP + 8'(4 * i))) begin
          t2_cmp_q[i] <= pwdata[W-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CT_REGS; i++) begin
        ct_cmp_q[i] <= compare_pkg::CMP_RESET;
      end
    end else if (wr) begin
      for (int i = 0; i < CT_REGS; i++) begin
        if (paddr == 8'(compare_pkg::OFF_CT_CMP + 8'(4 * i))) begin
          ct_cmp_q[i] <= pwdata[W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer 2 channels: mode 0 PWM or mode 1 latch pair per register
  assign port1_wr = wr && (paddr == compare_pkg::OFF_PORT1);

  genvar g;
  generate
    for (g = 0; g < T2_REGS; g++) begin : g_t2
      assign t2_eq[g] = (t2_count == t2_cmp_q[g]);
      // Writes reach the pair only in mode 1; mode 0 ignores the port
      assign m1_wr[g] = port1_wr && t2_en_q[g] && timer2_compare_mode_select_q; // see R5 see R19

      pwm_compare_channel #(
        .W(W),
        .SPIKE_BOTH(1'b0)
      ) u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .count(t2_count),
        .cmp(t2_cmp_q[g]),
        .pwm_q(t2_pwm[g])
      ); // see R4 see R18

      shadow_latch_pair u_pair (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(m1_wr[g]),
        .wr_val(pwdata[g]),
        .match(t2_eq[g] && t2_en_q[g] && timer2_compare_mode_select_q),
        .shadow_q(shadow[g]),
        .port_q(m1_port[g])
      ); // see R6 see R18
    end
  endgenerate

  // Plain port latch, used while compare is disabled on a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_latch_q <= '1;
    end else if (port1_wr) begin
      for (int i = 0; i < T2_REGS; i++) begin
        if (!t2_en_q[i]) begin
          port1_latch_q[i] <= pwdata[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_out <= '1;
    end else begin
      for (int i = 0; i < T2_REGS; i++) begin
        if (!t2_en_q[i]) begin
          port1_out[i] <= port1_latch_q[i];
        end else if (timer2_compare_mode_select_q) begin
          port1_out[i] <= m1_port[i]; // see R5 see R20
        end else begin
          port1_out[i] <= t2_pwm[i]; // see R19 see R20
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare timer channels, mode 0 only
  generate
    for (g = 0; g < CT_REGS; g++) begin : g_ct
      pwm_compare_channel #(
        .W(W),
        .SPIKE_BOTH(1'b1)
      ) u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .count(ct_count),
        .cmp(ct_cmp_q[g]),
        .pwm_q(ct_pwm[g])
      ); // see R3 see R4
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port4_latch_q <= '1;
    end else if (wr && (paddr == compare_pkg::OFF_PORT4)) begin
      port4_latch_q <= pwdata[CT_REGS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port4_out <= '1;
    end else begin
      for (int i = 0; i < CT_REGS; i++) begin
        port4_out[i] <= ct_en_q[i] ? ct_pwm[i] : port4_latch_q[i]; // see R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode 2: set and clear registers against timer 2
  assign set_eq = (t2_count == set_cmp_q);
  assign clr_eq = (t2_count == clr_cmp_q);
  // Edge of equality, so a stalled timer does not keep firing
  assign set_hit = set_eq && !set_eq_q;
  assign clr_hit = clr_eq && !clr_eq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_eq_q <= 1'b0;
      clr_eq_q <= 1'b0;
    end else begin
      set_eq_q <= set_eq;
      clr_eq_q <= clr_eq;
    end
  end

  assign mode2_on = t2_en_q[T2_REGS-1] &&
    ({fourth_q[compare_pkg::FOURTH_MODE_HIGH_BIT], fourth_q[compare_pkg::FOURTH_MODE_LOW_BIT]}
     == compare_pkg::FOURTH_COMPARE_MODE) &&
    ({fourth_q[compare_pkg::FOURTH_CONC1_BIT], fourth_q[compare_pkg::FOURTH_CONC0_BIT]}
     == compare_pkg::CONC_MODE2_CODE); // see R9 see R15
  assign pin_count = fourth_q[compare_pkg::FOURTH_COUNT_LSB +: 3];

  always_comb begin
    for (int i = 0; i < P5_PINS; i++) begin
      pin_sel[i] = mode2_on && (3'(i) <= pin_count); // see R16 see R21
    end
  end

  // Software write first, then clear, then set, so set wins a tie
  always_comb begin
    port5_d = port5_q;
    if (wr && (paddr == compare_pkg::OFF_PORT5)) begin
      port5_d = pwdata[P5_PINS-1:0]; // see R14
    end
    if (clr_hit) begin
      port5_d = port5_d & ~(clr_mask_q[P5_PINS-1:0] & pin_sel); // see R12 see R21
    end
    if (set_hit) begin
      port5_d = port5_d | (set_mask_q[P5_PINS-1:0] & pin_sel); // see R11 see R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port5_q <= compare_pkg::PORT_RESET;
      port5_out <= compare_pkg::PORT_RESET;
    end else begin
      port5_q <= port5_d;
      port5_out <= port5_d; // see R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match events work without mode 2; hardware set beats write-one-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_q <= 2'h0;
      set_match_irq <= 1'b0;
      clr_match_irq <= 1'b0;
    end else begin
      set_match_irq <= set_hit; // see R17
      clr_match_irq <= clr_hit; // see R17
      for (int i = 0; i < 2; i++) begin
        if (wr && (paddr == compare_pkg::OFF_EVENTS) && pwdata[i]) begin
          events_q[i] <= 1'b0;
        end
      end
      if (set_hit) begin
        events_q[compare_pkg::EVT_SET_BIT] <= 1'b1; // see R17
      end
      if (clr_hit) begin
        events_q[compare_pkg::EVT_CLR_BIT] <= 1'b1; // see R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_data = compare_pkg::RD_ZERO;
    case (paddr)
      compare_pkg::OFF_CTRL: rd_data[compare_pkg::CTRL_TIMER2_COMPARE_MODE_SELECT_BIT] = timer2_compare_mode_select_q;
      compare_pkg::OFF_T2_EN: rd_data[T2_REGS-1:0] = t2_en_q;
      compare_pkg::OFF_FOURTH: rd_data[7:0] = fourth_q;
      compare_pkg::OFF_CT_EN: rd_data[CT_REGS-1:0] = ct_en_q;
      compare_pkg::OFF_SET_CMP: rd_data[W-1:0] = set_cmp_q;
      compare_pkg::OFF_CLR_CMP: rd_data[W-1:0] = clr_cmp_q;
      compare_pkg::OFF_SET_MASK: rd_data[7:0] = set_mask_q;
      compare_pkg::OFF_CLR_MASK: rd_data[7:0] = clr_mask_q;
      compare_pkg::OFF_PORT5: rd_data[P5_PINS-1:0] = port5_pin_in; // see R14
      compare_pkg::OFF_PORT1: rd_data[T2_REGS-1:0] = port1_pin_in; // see R8
      compare_pkg::OFF_SHADOW: rd_data[T2_REGS-1:0] = shadow; // see R8
      compare_pkg::OFF_EVENTS: rd_data[1:0] = events_q;
      compare_pkg::OFF_PORT4: rd_data[CT_REGS-1:0] = port4_latch_q;
      default: begin
        for (int i = 0; i < T2_REGS; i++) begin
          if (paddr == 8'(compare_pkg::OFF_T2_CMP + 8'(4 * i))) begin
            rd_data[W-1:0] = t2_cmp_q[i];
          end
        end
        for (int i = 0; i < CT_REGS; i++) begin
          if (paddr == 8'(compare_pkg::OFF_CT_CMP + 8'(4 * i))) begin
            rd_data[W-1:0] = ct_cmp_q[i];
          end
        end
      end
    endcase
  end
endmodule
`default_nettype wire

//--- compare_output_modes_checker.sv
// Port-level assertions for the compare output block.
`timescale 1ns/10ps
`default_nettype none
module compare_output_modes_checker #(
  parameter int P5_PINS = 8
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Compare outputs
  input wire logic [P5_PINS-1:0] port5_out,
  input wire logic set_match_irq,
  input wire logic clr_match_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ready_second_cycle: assert property (s_first_access |=> pready)
    else $error("pready missing in second access cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable) && psel && penable)
    else $error("pready outside an access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_write_rdata_zero: assert property (s_done ##0 pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");
  a_misaligned_err: assert property (s_done ##0 (paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  a_set_irq_pulse: assert property (set_match_irq |=> !set_match_irq)
    else $error("set match event longer than one cycle");
  a_clr_irq_pulse: assert property ($rose(clr_match_irq) |=> $fell(clr_match_irq))
    else $error("clear match event longer than one cycle");
  // Pins move only on a match event or right after a completed write
  a_port5_cause: assert property ($changed(port5_out) |-> set_match_irq || clr_match_irq
      || ($past(psel) && $past(penable) && $past(pready) && $past(pwrite)))
    else $error("port five changed without a cause");
endmodule
`default_nettype wire

//--- compare_output_modes_tb.sv
// Self-checking testbench for the compare output block.
`timescale 1ns/10ps
`default_nettype none
module compare_output_modes_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] t2_count = 16'h0;
  logic [15:0] ct_count = 16'h0;
  logic [4:0] port1_pin_in;
  logic [7:0] port5_pin_in;
  logic [4:0] port1_out;
  logic [7:0] port4_out;
  logic [7:0] port5_out;
  logic set_match_irq;
  logic clr_match_irq;
  logic [64:0] note_q[$];
  logic [64:0] note;
  logic [15:0] v;
  int error_cnt = 0;
  int n_compared = 0;

  always #12.5 pclk = ~pclk;

  compare_output_modes i_compare_output_modes (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t2_count(t2_count), .ct_count(ct_count),
    .port1_pin_in(port1_pin_in), .port5_pin_in(port5_pin_in), .port1_out(port1_out),
    .port4_out(port4_out), .port5_out(port5_out), .set_match_irq(set_match_irq),
    .clr_match_irq(clr_match_irq));
  compare_pin_load i_compare_pin_load (.port1_out(port1_out), .port5_out(port5_out),
    .port1_pin_in(port1_pin_in), .port5_pin_in(port5_pin_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic [31:0] m, input logic err);
    note_q.push_back({err, m, exp});
    // Start on an edge, so a call after tick never drives mid-cycle
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'hffff_ffff, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0, exp, m, 1'b0);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic pwm(input logic ct, input logic [15:0] c, input logic e);
    @(posedge pclk);
    if (ct)
      ct_count <= c;
    else
      t2_count <= c;
    tick(3);
    chk("pwm pin", {31'h0, ct ? port4_out[0] : port1_out[0]}, {31'h0, e});
  endtask

  // Move off the value first: only the edge into equality acts
  task automatic m2(input logic [15:0] c, input logic [7:0] e, input logic [1:0] ev);
    @(posedge pclk);
    t2_count <= 16'h0;
    @(posedge pclk);
    t2_count <= c;
    tick(1);
    chk("port5", {24'h0, port5_out}, {24'h0, e});
    chk("events", {30'h0, clr_match_irq, set_match_irq}, {30'h0, ev});
  endtask

  task automatic conclude();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && note_q.size() > 0) begin
      note = note_q.pop_front();
      chk("prdata", prdata & note[63:32], note[31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, note[64]});
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    void'($urandom(32'ha20e));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk("port1", {27'h0, port1_out}, 32'h1f);
    chk("port5", {24'h0, port5_out}, 32'hff);
    rd(compare_pkg::OFF_SET_CMP, 32'h0, 32'hffff_ffff);
    apb(1'b0, 8'h50, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
    apb(1'b1, 8'h26, 32'h1, 32'h0, 32'hffff_ffff, 1'b1);
    v = 16'h0100 + 16'($urandom_range(32'h7fff));
    // Mode 0, timer 2 channel 0
    wr(compare_pkg::OFF_CTRL, 32'h0);
    wr(compare_pkg::OFF_T2_EN, 32'h1);
    wr(compare_pkg::OFF_T2_CMP, {16'h0, v});
    pwm(1'b0, v - 16'h1, 1'b0);
    pwm(1'b0, v, 1'b1);
    wr(compare_pkg::OFF_PORT1, 32'h0);
    pwm(1'b0, v + 16'h1, 1'b1);
    pwm(1'b0, 16'hffff, 1'b0);
    wr(compare_pkg::OFF_T2_CMP, 32'hffff);
    pwm(1'b0, 16'hfffe, 1'b0);
    // Compare timer channel 0
    wr(compare_pkg::OFF_CT_EN, 32'h1);
    wr(compare_pkg::OFF_CT_CMP, {16'h0, v});
    pwm(1'b1, v, 1'b0);
    pwm(1'b1, v + 16'h1, 1'b1);
    pwm(1'b1, 16'hffff, 1'b0);
    wr(compare_pkg::OFF_CT_CMP, 32'h0);
    pwm(1'b1, 16'h0, 1'b0);
    // Mode 1, timer 2 channel 1
    @(posedge pclk);
    t2_count <= 16'h0;
    wr(compare_pkg::OFF_CTRL, 32'h1);
    wr(compare_pkg::OFF_T2_EN, 32'h2);
    wr(compare_pkg::OFF_T2_CMP + 8'h04, {16'h0, v});
    wr(compare_pkg::OFF_PORT1, 32'h0);
    tick(3);
    chk("shadow hold", {31'h0, port1_out[1]}, 32'h1);
    rd(compare_pkg::OFF_SHADOW, 32'h0, 32'h2);
    rd(compare_pkg::OFF_PORT1, 32'h2, 32'h2);
    t2_count <= v;
    tick(3);
    chk("match load", {31'h0, port1_out[1]}, 32'h0);
    wr(compare_pkg::OFF_PORT1, 32'h1f);
    tick(2);
    chk("transparent", {31'h0, port1_out[1]}, 32'h1);
    @(posedge pclk);
    t2_count <= 16'h0;
    wr(compare_pkg::OFF_PORT1, 32'h0);
    tick(3);
    chk("no match", {31'h0, port1_out[1]}, 32'h1);
    // Mode 2 on the four lowest port five pins
    wr(compare_pkg::OFF_PORT5, 32'h0);
    wr(compare_pkg::OFF_T2_EN, 32'h10);
    wr(compare_pkg::OFF_FOURTH, 32'h3e);
    wr(compare_pkg::OFF_SET_MASK, 32'hff);
    wr(compare_pkg::OFF_CLR_MASK, 32'hff);
    wr(compare_pkg::OFF_SET_CMP, {16'h0, v});
    wr(compare_pkg::OFF_CLR_CMP, {16'h0, v + 16'h5});
    m2(v, 8'h0f, 2'b01);
    m2(v + 16'h5, 8'h00, 2'b10);
    wr(compare_pkg::OFF_CLR_CMP, {16'h0, v});
    m2(v, 8'h0f, 2'b11);
    wr(compare_pkg::OFF_SET_MASK, 32'h05);
    wr(compare_pkg::OFF_CLR_CMP, {16'h0, v + 16'h9});
    wr(compare_pkg::OFF_PORT5, 32'h0);
    m2(v, 8'h05, 2'b01);
    rd(compare_pkg::OFF_PORT5, 32'h05, 32'hff);
    rd(compare_pkg::OFF_EVENTS, 32'h3, 32'h3);
    wr(compare_pkg::OFF_EVENTS, 32'h3);
    rd(compare_pkg::OFF_EVENTS, 32'h0, 32'h3);
    // Match events without touching the pins
    wr(compare_pkg::OFF_FOURTH, 32'h0);
    wr(compare_pkg::OFF_PORT5, 32'ha0);
    m2(v, 8'ha0, 2'b01);
    conclude();
  end
endmodule

bind compare_output_modes compare_output_modes_checker #(.P5_PINS(P5_PINS)) i_compare_output_modes_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port5_out(port5_out),
  .set_match_irq(set_match_irq), .clr_match_irq(clr_match_irq));
`default_nettype wire

//--- compare_pin_load.sv
// External circuitry on the compare pins, reflecting the driven levels.
`timescale 1ns/10ps
`default_nettype none
module compare_pin_load (
  // Driven pins
  input wire logic [4:0] port1_out,
  input wire logic [7:0] port5_out,
  // Levels read back
  output logic [4:0] port1_pin_in,
  output logic [7:0] port5_pin_in
);
  // Push-pull drivers, so the pin follows its latch
  assign port1_pin_in = port1_out;
  assign port5_pin_in = port5_out;
endmodule
`default_nettype wire

//--- compare_pkg.sv
// Constants shared by the compare output block: offsets, fields, reset values.
// Notes on behaviour
// R1: An n-bit compare register gives 2^n PWM duty settings, lowest is constant low.
// R2: Equal timer and compare width never reach full duty; a one-clock low spike remains.
// R3: Timer 2 pairing puts the spike at period end; compare timer at both ends.
// R4: Mode 0 works with timer 2 registers and with the compare timer's eight registers.
// R5: Mode 1 is only for timer 2 registers; software controls both edges.
// R6: In mode 1 port writes go to a shadow latch, moved to the pin on match.
// R7: While the match signal is active both latches are transparent to writes.
// R8: In mode 1 read-modify-write uses the shadow latch; ordinary reads return pin level.
// R9: In mode 2 port five pins are driven by the set and clear compare registers.
// R10: Set and clear compare registers are 16 bits, always compared with timer 2.
// R11: A set compare match drives high every port five pin enabled in the set mask.
// R12: A clear compare match drives low every port five pin enabled in the clear mask.
// R13: When set and clear matches coincide, the set action wins.
// R14: Port five pins in mode 2 still take software writes and can be read.
// R15: Software selects mode 2 via fourth register mode bits 1,0 and concurrent enables.
// R16: A three-bit field selects how many port five pins carry the compare function.
// R17: Set and clear matches raise interrupts alone, even without the fourth register enabled.
// R18: Reload register and first three compare registers support modes 0 and 1.
// R19: Mode 0 drives high on match, low on overflow; port writes are ignored.
// R20: The timer 2 mode bit picks mode 0 when clear and mode 1 when set.
// R21: Mask bit i maps to port five pin i; pins beyond the count stay ordinary.
package compare_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_T2_EN = 8'h04;
  localparam logic [7:0] OFF_FOURTH = 8'h08;
  localparam logic [7:0] OFF_CT_EN = 8'h0c;
  localparam logic [7:0] OFF_T2_CMP = 8'h10;
  localparam logic [7:0] OFF_SET_CMP = 8'h24;
  localparam logic [7:0] OFF_CLR_CMP = 8'h28;
  localparam logic [7:0] OFF_SET_MASK = 8'h2c;
  localparam logic [7:0] OFF_CLR_MASK = 8'h30;
  localparam logic [7:0] OFF_PORT5 = 8'h34;
  localparam logic [7:0] OFF_PORT1 = 8'h38;
  localparam logic [7:0] OFF_SHADOW = 8'h3c;
  localparam logic [7:0] OFF_EVENTS = 8'h40;
  localparam logic [7:0] OFF_PORT4 = 8'h44;
  localparam logic [7:0] OFF_CT_CMP = 8'h60;
  localparam int CTRL_TIMER2_COMPARE_MODE_SELECT_BIT = 0;
  localparam int FOURTH_MODE_LOW_BIT = 0;
  localparam int FOURTH_MODE_HIGH_BIT = 1;
  localparam int FOURTH_CONC0_BIT = 2;
  localparam int FOURTH_CONC1_BIT = 3;
  localparam int FOURTH_COUNT_LSB = 4;
  localparam int EVT_SET_BIT = 0;
  localparam int EVT_CLR_BIT = 1;
  localparam logic [1:0] FOURTH_COMPARE_MODE = 2'h2;
  localparam logic [1:0] CONC_MODE2_CODE = 2'h3;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

//--- pwm_compare_channel.sv
// One compare mode 0 channel: PWM level from timer count and compare value.
`timescale 1ns/10ps
`default_nettype none
module pwm_compare_channel #(
  parameter int W = 16,
  parameter bit SPIKE_BOTH = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer and compare value
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] cmp,
  // Output level
  output logic pwm_q
);
  logic at_top;
  logic hi_d;

  assign at_top = (count == {W{1'b1}});

  // High after the match, low from overflow onward; cmp at top gives 0%
  always_comb begin
    if (SPIKE_BOTH) begin
      hi_d = (count > cmp) && !at_top; // see R3
    end else begin
      hi_d = (count >= cmp) && !at_top; // see R1 see R2 see R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= hi_d;
    end
  end
endmodule
`default_nettype wire

//--- shadow_latch_pair.sv
// Compare mode 1 latch pair: software shadow and pin-facing port latch.
`timescale 1ns/10ps
`default_nettype none
module shadow_latch_pair (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Software write and compare signal
  input wire logic wr_en,
  input wire logic wr_val,
  input wire logic match,
  // Latch contents
  output logic shadow_q,
  output logic port_q
);
  logic shadow_d;

  assign shadow_d = wr_en ? wr_val : shadow_q; // see R6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= 1'b1;
    end else begin
      shadow_q <= shadow_d;
    end
  end

  // Transparent while match is high, so a write then reaches both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q <= 1'b1;
    end else if (match) begin
      port_q <= shadow_d; // see R6 see R7
    end
  end
endmodule
`default_nettype wire
